// File: rtl/ufs_pkg.sv
// constants and types for the uart fifo alias, halt and id register bank
//==================================================================
// Functional notes
// - rx alias reads/writes fifo control rx bits
// - rx codes: one, quarter, half, two short
// - rx data interrupt at chosen fill
// - dma mode one: rx request follows threshold
// - tx alias reads/writes fifo control tx bits
// - tx codes: empty, two, quarter, half
// - programmable mode: tx interrupt at threshold
// - halt bit stops sending, resets zero
// - halt ignored while fifos disabled
// - fifo enable falling flushes both fifos
//==================================================================
package ufs_pkg;
    // byte addresses of the bank
    localparam logic [31:0] CTL_ADDR = 32'h50001088;
    localparam logic [31:0] RX_ALIAS_ADDR = 32'h5000109C;
    localparam logic [31:0] TX_ALIAS_ADDR = 32'h500010A0;
    localparam logic [31:0] HALT_ADDR = 32'h500010A4;
    localparam logic [31:0] PARAM_ADDR = 32'h500010F4;
    localparam logic [31:0] VER_ADDR = 32'h500010F8;
    localparam logic [31:0] TYPE_ADDR = 32'h500010FC;
    // receive threshold codes
    localparam logic [1:0] RX_TRIG_ONE = 2'h0;
    localparam logic [1:0] RX_TRIG_QUARTER = 2'h1;
    localparam logic [1:0] RX_TRIG_HALF = 2'h2;
    localparam logic [1:0] RX_TRIG_SHORT2 = 2'h3;
    // transmit empty threshold codes
    localparam logic [1:0] TX_TRIG_EMPTY = 2'h0;
    localparam logic [1:0] TX_TRIG_TWO = 2'h1;
    localparam logic [1:0] TX_TRIG_QUARTER = 2'h2;
    localparam logic [1:0] TX_TRIG_HALF = 2'h3;
    // fixed fill figures
    localparam int RX_ONE_LEVEL = 1;
    localparam int RX_FULL_MARGIN = 2;
    localparam int TX_TWO_LEVEL = 2;
    // reset values
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic HALT_RESET = 1'b0;
    localparam logic [15:0] PARAM_RESET = 16'h0000;
    // fifo control word, msb first as software sees it
    typedef struct packed {
        logic [1:0] rx_trig;  // receive threshold
        logic [1:0] tx_trig;  // transmit empty threshold
        logic dma_mode;       // dma signalling mode
        logic tx_reset;       // self clearing tx flush
        logic rx_reset;       // self clearing rx flush
        logic enable;         // fifo enable
    } ufs_ctl_t;
endpackage

// File: rtl/ufs_regs.sv
// fifo threshold aliases, transmit halt and component id registers
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ufs_regs #(
    parameter int FIFO_DEPTH = 16,                   // fifo entries
    parameter logic [15:0] VER_VALUE = 16'h0A5A,     // arbitrary value
    parameter logic [15:0] TYPE_VALUE = 16'h0C3C,    // arbitrary value
    parameter int LVL_W = $clog2(FIFO_DEPTH + 1)     // fill count width
) (
    input wire logic ref_clk_in,                     // 100 mhz clock
    input wire logic reset_in,                       // sync reset, high
    input wire logic [31:0] addr_in,                 // byte address
    input wire logic [31:0] wdata_in,                // write data
    input wire logic wr_in,                          // write strobe
    input wire logic rd_in,                          // read strobe
    output logic [31:0] rdata_out,                   // read data, +1 cycle
    input wire logic [LVL_W-1:0] rx_level_in,        // rx fifo fill
    input wire logic [LVL_W-1:0] tx_level_in,        // tx fifo fill
    input wire logic ptime_mode_in,                  // prog tx irq mode
    output ufs_pkg::ufs_ctl_t fifo_ctrl_out,         // stored control
    output logic rx_fifo_flush_out,                  // rx flush pulse
    output logic tx_fifo_flush_out,                  // tx flush pulse
    output logic halt_tx_out,                        // stop serial tx
    output logic rx_data_irq_out,                    // rx data available
    output logic tx_empty_irq_out,                   // tx empty irq
    output logic rx_dma_req_n_out                    // rx dma req, low
);

    //==============================================================
    // elaboration check
    //==============================================================
    // quarter of the depth must not fall below the two-entry figures
    if (FIFO_DEPTH < 8) begin : g_depth_check
        $error("ufs_regs: FIFO_DEPTH must be at least 8");
    end

    //==============================================================
    // threshold constants sized to the fill counter
    //==============================================================
    localparam logic [LVL_W-1:0] RX_LVL_ONE =
        LVL_W'(ufs_pkg::RX_ONE_LEVEL);
    localparam logic [LVL_W-1:0] LVL_QUARTER =
        LVL_W'(FIFO_DEPTH / 4);
    localparam logic [LVL_W-1:0] LVL_HALF =
        LVL_W'(FIFO_DEPTH / 2);
    localparam logic [LVL_W-1:0] RX_LVL_SHORT2 =
        LVL_W'(FIFO_DEPTH - ufs_pkg::RX_FULL_MARGIN);
    localparam logic [LVL_W-1:0] TX_LVL_TWO =
        LVL_W'(ufs_pkg::TX_TWO_LEVEL);
    localparam logic [LVL_W-1:0] LVL_ZERO = '0;

    //==============================================================
    // state
    //==============================================================
    ufs_pkg::ufs_ctl_t ctl;            // one shared control word
    ufs_pkg::ufs_ctl_t next_ctl;       // its next value
    logic halt;                        // halt bit as written
    logic next_halt;                   // its next value
    logic [31:0] rdata;                // read data register
    logic [31:0] next_rdata;           // its next value
    logic rx_flush;                    // rx flush pulse register
    logic next_rx_flush;               // its next value
    logic tx_flush;                    // tx flush pulse register
    logic next_tx_flush;               // its next value
    logic halt_eff;                    // gated halt register
    logic next_halt_eff;               // its next value
    logic rx_irq;                      // rx interrupt register
    logic next_rx_irq;                 // its next value
    logic tx_irq;                      // tx interrupt register
    logic next_tx_irq;                 // its next value
    logic rx_dma_n;                    // rx dma request register
    logic next_rx_dma_n;               // its next value

    // address decode strobes
    logic hit_ctl;                     // fifo control word
    logic hit_rx_alias;                // rx threshold alias
    logic hit_tx_alias;                // tx threshold alias
    logic hit_halt;                    // transmit halt
    logic hit_param;                   // component parameters
    logic hit_ver;                     // component version
    logic hit_type;                    // component type

    // decoded thresholds
    logic [LVL_W-1:0] rx_thr;          // rx fill that triggers
    logic [LVL_W-1:0] tx_thr;          // tx fill that triggers
    logic rx_reached;                  // rx fill at or above rx_thr
    logic tx_reached;                  // tx fill at or below tx_thr
    logic en_fall;                     // fifo enable being cleared

    //==============================================================
    // address decode
    //==============================================================
    // exact word compare; anything else is unmapped
    always_comb begin
        hit_ctl = (addr_in == ufs_pkg::CTL_ADDR);
        hit_rx_alias = (addr_in == ufs_pkg::RX_ALIAS_ADDR);
        hit_tx_alias = (addr_in == ufs_pkg::TX_ALIAS_ADDR);
        hit_halt = (addr_in == ufs_pkg::HALT_ADDR);
        hit_param = (addr_in == ufs_pkg::PARAM_ADDR);
        hit_ver = (addr_in == ufs_pkg::VER_ADDR);
        hit_type = (addr_in == ufs_pkg::TYPE_ADDR);
    end

    //==============================================================
    // control word and halt bit, next values
    //==============================================================
    // every alias lands in the same fcr flops, so a read from any
    // location returns the last value written through any of them
    always_comb begin
        next_ctl = ctl;
        next_halt = halt;
        // flush bits never hold; they only make a pulse
        next_ctl.rx_reset = 1'b0;
        next_ctl.tx_reset = 1'b0;
        if (wr_in && hit_ctl) begin
            // full word write
            next_ctl = ufs_pkg::ufs_ctl_t'(wdata_in[7:0]);
            next_ctl.rx_reset = 1'b0;
            next_ctl.tx_reset = 1'b0;
        end
        if (wr_in && hit_rx_alias) begin
            // only the rx threshold moves
            next_ctl.rx_trig = wdata_in[1:0];
        end
        if (wr_in && hit_tx_alias) begin
            // only the tx threshold moves
            next_ctl.tx_trig = wdata_in[1:0];
        end
        if (wr_in && hit_halt) begin
            // halt bit is plain storage
            next_halt = wdata_in[0];
        end
        // id registers have no storage; writes fall away
    end

    //==============================================================
    // flush pulses, next values
    //==============================================================
    // dropping the enable resets both fifo controllers; an explicit
    // flush bit in an fcr write flushes its own fifo only
    always_comb begin
        en_fall = ctl.enable && !next_ctl.enable;
        next_rx_flush = en_fall;
        next_tx_flush = en_fall;
        if (wr_in && hit_ctl) begin
            // self clearing flush requests
            if (wdata_in[1]) begin
                next_rx_flush = 1'b1;
            end
            if (wdata_in[2]) begin
                next_tx_flush = 1'b1;
            end
        end
    end

    //==============================================================
    // threshold decode
    //==============================================================
    // fractions follow the depth parameter, so a deeper fifo keeps
    // the same meaning for each code
    always_comb begin
        case (ctl.rx_trig)
            ufs_pkg::RX_TRIG_ONE: begin
                rx_thr = RX_LVL_ONE;
            end
            ufs_pkg::RX_TRIG_QUARTER: begin
                rx_thr = LVL_QUARTER;
            end
            ufs_pkg::RX_TRIG_HALF: begin
                rx_thr = LVL_HALF;
            end
            ufs_pkg::RX_TRIG_SHORT2: begin
                rx_thr = RX_LVL_SHORT2;
            end
            default: begin
                rx_thr = RX_LVL_ONE;
            end
        endcase
        case (ctl.tx_trig)
            ufs_pkg::TX_TRIG_EMPTY: begin
                tx_thr = LVL_ZERO;
            end
            ufs_pkg::TX_TRIG_TWO: begin
                tx_thr = TX_LVL_TWO;
            end
            ufs_pkg::TX_TRIG_QUARTER: begin
                tx_thr = LVL_QUARTER;
            end
            ufs_pkg::TX_TRIG_HALF: begin
                tx_thr = LVL_HALF;
            end
            default: begin
                tx_thr = LVL_ZERO;
            end
        endcase
    end

    //==============================================================
    // events toward the rest of the uart, next values
    //==============================================================
    // without fifos the thresholds mean nothing: one character
    // pending is data available, and an empty holder is tx empty
    always_comb begin
        rx_reached = (rx_level_in >= rx_thr);
        tx_reached = (tx_level_in <= tx_thr);
        // received data available
        if (ctl.enable) begin
            next_rx_irq = rx_reached;
        end else begin
            next_rx_irq = (rx_level_in != LVL_ZERO);
        end
        // transmitter empty, threshold only in programmable mode
        if (ctl.enable && ptime_mode_in) begin
            next_tx_irq = tx_reached;
        end else begin
            next_tx_irq = (tx_level_in == LVL_ZERO);
        end
        // rx dma request, active low
        if (ctl.enable && ctl.dma_mode) begin
            next_rx_dma_n = !rx_reached;
        end else begin
            // mode zero: any pending character asks for service
            next_rx_dma_n = (rx_level_in == LVL_ZERO);
        end
        // halt only counts while fifos are on
        next_halt_eff = halt && ctl.enable;
    end

    //==============================================================
    // read mux, next value
    //==============================================================
    // data shows only in the cycle after the strobe; unmapped
    // addresses and idle cycles return zero
    always_comb begin
        next_rdata = '0;
        if (rd_in) begin
            if (hit_ctl) begin
                next_rdata[7:0] = ctl;
            end else if (hit_rx_alias) begin
                next_rdata[1:0] = ctl.rx_trig;
            end else if (hit_tx_alias) begin
                next_rdata[1:0] = ctl.tx_trig;
            end else if (hit_halt) begin
                next_rdata[0] = halt;
            end else if (hit_param) begin
                next_rdata[15:0] = ufs_pkg::PARAM_RESET;
            end else if (hit_ver) begin
                next_rdata[15:0] = VER_VALUE;
            end else if (hit_type) begin
                next_rdata[15:0] = TYPE_VALUE;
            end else begin
                next_rdata = '0;
            end
        end
    end

    //==============================================================
    // registers
    //==============================================================
    // single clocked process; reset puts every output at idle
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ctl <= ufs_pkg::ufs_ctl_t'(ufs_pkg::CTL_RESET);
            halt <= ufs_pkg::HALT_RESET;
            rdata <= '0;
            rx_flush <= 1'b0;
            tx_flush <= 1'b0;
            halt_eff <= 1'b0;
            rx_irq <= 1'b0;
            tx_irq <= 1'b0;
            rx_dma_n <= 1'b1;
        end else begin
            ctl <= next_ctl;
            halt <= next_halt;
            rdata <= next_rdata;
            rx_flush <= next_rx_flush;
            tx_flush <= next_tx_flush;
            halt_eff <= next_halt_eff;
            rx_irq <= next_rx_irq;
            tx_irq <= next_tx_irq;
            rx_dma_n <= next_rx_dma_n;
        end
    end

    //==============================================================
    // outputs, each straight from a flop
    //==============================================================
    assign rdata_out = rdata;
    assign fifo_ctrl_out = ctl;
    assign rx_fifo_flush_out = rx_flush;
    assign tx_fifo_flush_out = tx_flush;
    assign halt_tx_out = halt_eff;
    assign rx_data_irq_out = rx_irq;
    assign tx_empty_irq_out = tx_irq;
    assign rx_dma_req_n_out = rx_dma_n;

endmodule // ufs_regs
`default_nettype wire

// File: tb/ufs_regs_chk.sv
// assertion checker for the fifo alias, halt and id register bank
`timescale 1ns/1ps
`default_nettype none
module ufs_regs_chk #(
    parameter int FIFO_DEPTH = 16, // fifo entries
    parameter int LVL_W = 5 // fill count width
) (
    input wire logic ref_clk_in, // clock
    input wire logic reset_in, // sync reset, high
    input wire logic [31:0] addr_in, // byte address
    input wire logic [31:0] wdata_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    input wire logic [31:0] rdata_out, // read data
    input wire logic [LVL_W-1:0] rx_level_in, // rx fill
    input wire logic [LVL_W-1:0] tx_level_in, // tx fill
    input wire logic ptime_mode_in, // prog tx mode
    input wire ufs_pkg::ufs_ctl_t fifo_ctrl_out, // control word
    input wire logic rx_fifo_flush_out, // rx flush pulse
    input wire logic tx_fifo_flush_out, // tx flush pulse
    input wire logic halt_tx_out, // halt level
    input wire logic rx_data_irq_out, // rx irq
    input wire logic tx_empty_irq_out, // tx irq
    input wire logic rx_dma_req_n_out // rx dma req, low
);
    //==========================================
    // helper logic
    logic rst_d; // reset one edge ago, masks the first edge after release
    int rx_thr; // rx fill that raises the irq
    int tx_thr; // tx fill that raises the irq
    logic exp_rx; // expected rx irq next cycle
    logic exp_tx; // expected tx irq next cycle
    always_ff @(posedge ref_clk_in) begin
        rst_d <= reset_in;
    end
    // thresholds from the stored codes
    always_comb begin
        case (fifo_ctrl_out.rx_trig)
            2'h0: rx_thr = 1;
            2'h1: rx_thr = FIFO_DEPTH / 4;
            2'h2: rx_thr = FIFO_DEPTH / 2;
            default: rx_thr = FIFO_DEPTH - 2;
        endcase
        case (fifo_ctrl_out.tx_trig)
            2'h0: tx_thr = 0;
            2'h1: tx_thr = 2;
            2'h2: tx_thr = FIFO_DEPTH / 4;
            default: tx_thr = FIFO_DEPTH / 2;
        endcase
        exp_rx = fifo_ctrl_out.enable ? (int'(rx_level_in) >= rx_thr) : (rx_level_in != '0);
        exp_tx = (fifo_ctrl_out.enable && ptime_mode_in) ? (int'(tx_level_in) <= tx_thr)
            : (tx_level_in == '0);
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in || rst_d);
    //==========================================
    // sequences
    sequence s_rx_wr;
        wr_in && addr_in == ufs_pkg::RX_ALIAS_ADDR;
    endsequence
    sequence s_tx_wr;
        wr_in && addr_in == ufs_pkg::TX_ALIAS_ADDR;
    endsequence
    sequence s_fifo_off;
        fifo_ctrl_out.enable ##1 !fifo_ctrl_out.enable;
    endsequence
    //==========================================
    // assertions
    chk_rdata_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data not zero outside a read");
    chk_rx_alias_read: assert property (rd_in && addr_in == ufs_pkg::RX_ALIAS_ADDR
        |=> rdata_out == {30'h0, $past(fifo_ctrl_out.rx_trig)})
        else $error("rx alias read wrong");
    chk_ctl_write: assert property (wr_in && addr_in == ufs_pkg::CTL_ADDR
        |=> fifo_ctrl_out == {$past(wdata_in[7:3]), 2'h0, $past(wdata_in[0])})
        else $error("control write not stored");
    chk_rx_alias_wr: assert property (s_rx_wr |=> fifo_ctrl_out.rx_trig == $past(wdata_in[1:0])
        && $stable(fifo_ctrl_out.tx_trig)) else $error("rx alias write wrong");
    chk_tx_alias_wr: assert property (s_tx_wr |=> fifo_ctrl_out.tx_trig == $past(wdata_in[1:0])
        && $stable(fifo_ctrl_out.rx_trig)) else $error("tx alias write wrong");
    chk_flush_both: assert property (s_fifo_off |-> rx_fifo_flush_out && tx_fifo_flush_out)
        else $error("fifo disable did not flush");
    chk_halt_gated: assert property (!fifo_ctrl_out.enable |=> !halt_tx_out)
        else $error("halt active with fifos off");
    chk_rx_irq: assert property (rx_data_irq_out == $past(exp_rx))
        else $error("rx irq level wrong");
    chk_tx_irq: assert property (tx_empty_irq_out == $past(exp_tx))
        else $error("tx irq level wrong");
    chk_rx_dma: assert property (fifo_ctrl_out.enable && fifo_ctrl_out.dma_mode
        |=> rx_dma_req_n_out == !$past(exp_rx)) else $error("rx dma request wrong");
endmodule // ufs_regs_chk
bind ufs_regs ufs_regs_chk #(.FIFO_DEPTH(FIFO_DEPTH), .LVL_W(LVL_W)) i_ufs_regs_chk (.*);
`default_nettype wire

// File: tb/ufs_fifo_model.sv
// fill counters standing in for the rest of the uart behind the bank
`timescale 1ns/1ps
`default_nettype none
module ufs_fifo_model #(
    parameter int LVL_W = 5 // fill count width
) (
    input wire logic ref_clk_in, // clock
    input wire logic reset_in, // sync reset
    input wire logic load_in, // load both fills
    input wire logic [LVL_W-1:0] rx_load_in, // rx fill to load
    input wire logic [LVL_W-1:0] tx_load_in, // tx fill to load
    input wire logic rx_flush_in, // rx flush pulse
    input wire logic tx_flush_in, // tx flush pulse
    input wire logic halt_in, // transmitter halt
    output logic [LVL_W-1:0] rx_level_out, // rx fill
    output logic [LVL_W-1:0] tx_level_out // tx fill
);
    // the transmitter sends one character a cycle unless halted
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            rx_level_out <= '0;
            tx_level_out <= '0;
        end else if (load_in) begin
            rx_level_out <= rx_load_in;
            tx_level_out <= tx_load_in;
        end else begin
            if (rx_flush_in) rx_level_out <= '0;
            if (tx_flush_in) tx_level_out <= '0;
            else if (!halt_in && tx_level_out != '0) tx_level_out <= tx_level_out - 1'b1;
        end
    end
endmodule // ufs_fifo_model
`default_nettype wire

// File: tb/ufs_regs_tb_top.sv
// self-checking bench for the fifo alias, halt and id register bank
`timescale 1ns/1ps
`default_nettype none
module ufs_regs_tb_top;
    //==========================================
    // signals
    localparam int LW = 5; // fill width at depth 16
    localparam logic [15:0] VER_ID = 16'h1234; // arbitrary value
    localparam logic [15:0] TYPE_ID = 16'h5678; // arbitrary value
    logic clk = 1'b0; // 100 mhz clock
    logic rst = 1'b1; // sync reset
    logic [31:0] addr = 32'h0; // bus address
    logic [31:0] wdata = 32'h0; // bus write data
    logic wr = 1'b0; // write strobe
    logic rd = 1'b0; // read strobe
    logic ptime = 1'b0; // prog tx irq mode
    logic ld = 1'b0; // model load strobe
    logic [LW-1:0] lrx = '0; // rx fill to load
    logic [LW-1:0] ltx = '0; // tx fill to load
    logic [31:0] rdata; // read data
    logic [LW-1:0] rx_lvl; // rx fill
    logic [LW-1:0] tx_lvl; // tx fill
    ufs_pkg::ufs_ctl_t ctl_word; // control word
    logic rxf, txf, halt, rxi, txi, dman; // flag outputs
    int n_errors = 0; // mismatches
    int checked = 0; // comparisons
    int rx_thr[4] = '{1, 4, 8, 14}; // rx fills per code at depth 16
    int tx_thr[4] = '{0, 2, 4, 8}; // tx fills per code at depth 16
    logic [31:0] ra[8] = '{ufs_pkg::CTL_ADDR, ufs_pkg::RX_ALIAS_ADDR, ufs_pkg::TX_ALIAS_ADDR,
        ufs_pkg::HALT_ADDR, ufs_pkg::PARAM_ADDR, ufs_pkg::VER_ADDR, ufs_pkg::TYPE_ADDR,
        32'h500010A8};
    logic [31:0] re[8] = '{0, 0, 0, 0, 0, {16'h0, VER_ID}, {16'h0, TYPE_ID}, 0}; // reset reads
    initial begin
        forever #5 clk = ~clk;
    end
    ufs_regs #(.FIFO_DEPTH(16), .VER_VALUE(VER_ID), .TYPE_VALUE(TYPE_ID)) i_ufs_regs (
        .ref_clk_in(clk), .reset_in(rst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
        .rd_in(rd), .rdata_out(rdata), .rx_level_in(rx_lvl), .tx_level_in(tx_lvl),
        .ptime_mode_in(ptime), .fifo_ctrl_out(ctl_word), .rx_fifo_flush_out(rxf),
        .tx_fifo_flush_out(txf), .halt_tx_out(halt), .rx_data_irq_out(rxi),
        .tx_empty_irq_out(txi), .rx_dma_req_n_out(dman));
    ufs_fifo_model #(.LVL_W(LW)) i_ufs_fifo_model (
        .ref_clk_in(clk), .reset_in(rst), .load_in(ld), .rx_load_in(lrx), .tx_load_in(ltx),
        .rx_flush_in(rxf), .tx_flush_in(txf), .halt_in(halt), .rx_level_out(rx_lvl),
        .tx_level_out(tx_lvl));
    //==========================================
    // tasks; each drives just after an edge; wrt and load return at the taking edge, rdc and w 1 ns after an edge
    task automatic cmpw(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cmpb(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic wrt(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rdc(input logic [31:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 cmpw("read data", e, rdata);
    endtask
    task automatic load(input int r, input int t);
        @(posedge clk);
        lrx <= LW'(r);
        ltx <= LW'(t);
        ld <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // watchdog against a hung run
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        complete_run();
    end
    //==========================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) rdc(ra[i], re[i]);
        wrt(ufs_pkg::VER_ADDR, 32'hFFFF);
        wrt(ufs_pkg::PARAM_ADDR, 32'hFFFF);
        rdc(ufs_pkg::VER_ADDR, {16'h0, VER_ID});
        rdc(ufs_pkg::PARAM_ADDR, 32'h0);
        $display("test ids done");
        wrt(ufs_pkg::CTL_ADDR, 32'hC9);
        rdc(ufs_pkg::RX_ALIAS_ADDR, 32'h3);
        wrt(ufs_pkg::RX_ALIAS_ADDR, 32'hFFFD);
        rdc(ufs_pkg::CTL_ADDR, 32'h49);
        wrt(ufs_pkg::TX_ALIAS_ADDR, 32'h2);
        rdc(ufs_pkg::CTL_ADDR, 32'h69);
        rdc(ufs_pkg::TX_ALIAS_ADDR, 32'h2);
        $display("test aliases done");
        for (int c = 0; c < 4; c++) begin
            wrt(ufs_pkg::RX_ALIAS_ADDR, c);
            load(rx_thr[c] - 1, 0);
            w(2);
            cmpb("rx irq", 1'b0, rxi);
            cmpb("rx dma", 1'b1, dman);
            load(rx_thr[c], 0);
            w(2);
            cmpb("rx irq", 1'b1, rxi);
            cmpb("rx dma", 1'b0, dman);
        end
        $display("test rx thresholds done");
        wrt(ufs_pkg::HALT_ADDR, 32'h1);
        ptime <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            wrt(ufs_pkg::TX_ALIAS_ADDR, c);
            load(0, tx_thr[c] + 1);
            w(3);
            cmpb("halt", 1'b1, halt);
            cmpw("tx fill", tx_thr[c] + 1, 32'(tx_lvl));
            cmpb("tx irq", 1'b0, txi);
            load(0, tx_thr[c]);
            w(2);
            cmpb("tx irq", 1'b1, txi);
        end
        ptime <= 1'b0;
        w(2);
        cmpb("tx irq", 1'b0, txi);
        $display("test tx thresholds done");
        load(3, 3);
        wrt(ufs_pkg::CTL_ADDR, 32'h0);
        #1 cmpb("rx flush", 1'b1, rxf);
        cmpb("tx flush", 1'b1, txf);
        w(2);
        cmpw("rx fill", 32'h0, 32'(rx_lvl));
        cmpb("halt", 1'b0, halt);
        load(0, 5);
        w(3);
        cmpw("tx fill", 32'h2, 32'(tx_lvl));
        wrt(ufs_pkg::HALT_ADDR, 32'h0);
        rdc(ufs_pkg::HALT_ADDR, 32'h0);
        $display("test flush and halt done");
        // explicit flush bits and dma mode zero
        wrt(ufs_pkg::CTL_ADDR, 32'h07);
        #1 cmpb("rx flush", 1'b1, rxf);
        cmpb("tx flush", 1'b1, txf);
        cmpw("control word", 32'h01, 32'(ctl_word));
        load(1, 0);
        w(2);
        cmpb("rx irq", 1'b1, rxi);
        cmpb("rx dma", 1'b0, dman);
        $display("test flush bits done");
        complete_run();
    end
endmodule // ufs_regs_tb_top
`default_nettype wire
